// file: hdl/tec_pkg.sv
package tec_pkg;
  // register map (byte offsets as printed)
  localparam logic [7:0] ADDR_COUNT_VALUE   = 8'h0D;
  localparam logic [7:0] ADDR_COUNTER_CTRL  = 8'h0E;
  localparam logic [7:0] ADDR_IRQ_CONTROL   = 8'h0F;
  localparam logic [7:0] ADDR_PORT_A_LATCH  = 8'h12;
  localparam logic [7:0] ADDR_STATUS        = 8'h10;
  // counter_control fields
  localparam int CTL_PSC_LSB  = 0;
  localparam int CTL_PSC_MSB  = 2;
  localparam int CTL_EDGE     = 3;
  localparam int CTL_RUN      = 4;
  localparam int CTL_UNUSED   = 5;
  localparam int CTL_MODE_LSB = 6;
  localparam int CTL_MODE_MSB = 7;
  localparam logic [7:0] CTL_RESET = 8'h08;
  // irq_control fields
  localparam int IRQ_ENABLE_BIT = 2;
  localparam int IRQ_FLAG_BIT   = 5;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK  = 8'h24;
  // port A latch
  localparam int LATCH_DIV_BIT = 3;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  // status bits
  localparam int ST_OVF_BIT = 0;
  localparam int ST_DIV_BIT = 1;
  // counter constants
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] ZERO8       = 8'h00;
  // modes
  localparam logic [1:0] MODE_UNUSED = 2'h0;
  localparam logic [1:0] MODE_EVENT  = 2'h1;
  localparam logic [1:0] MODE_TIMER  = 2'h2;
  localparam logic [1:0] MODE_PULSE  = 2'h3;
endpackage : tec_pkg

// file: hdl/tec_counter.sv
// Contract
// - one 8-bit up counter, fed by pin events or prescaled system clock
// - count register write loads counter logic; read returns present count
// - mode field 7:6: 01 event, 10 timer, 11 pulse width, 00 idle
// - event/timer modes count to FFH, reload preload, set flag bit 5
// - pulse mode counts from chosen pin edge to return edge, clears run
// - pulse result held; later edges ignored until run set again
// - pulse mode overflow also reloads and raises the overflow flag
// - control bit 4 enables counting when 1
// - event/timer modes never clear run bit in hardware
// - overflow is offered as a wake-up source pulse
// - cleared overflow enable bit 2 suppresses the interrupt request
// - stopped: write loads preload and counter; running: preload only
// - counter clock is blocked during a count register read
// - bits 2:0 divide system clock by two to the field value
// - event mode: edge bit 1 falling edges, 0 rising edges
// - pulse mode: edge bit 1 high pulse, 0 low pulse measured
// - control bit 5 reads back as zero
// - divider option drives port A bit 3, gated by its data latch
// - divider output toggles on each overflow
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tec_counter #(
  parameter int PSC_W = 7
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       count_pin_i,
  input  wire logic       freq_div_option_i,
  output logic            freq_divider_out_o,
  output logic            irq_o,
  output logic            wake_o
);

  logic [7:0]       count_value;
  logic [7:0]       preload;
  logic [7:0]       counter_control;
  logic [7:0]       irq_control;
  logic [7:0]       port_a_latch;
  logic [PSC_W-1:0] psc_cnt;
  logic [2:0]       pin_sync;
  logic             pin_level;
  logic             div_toggle;
  logic             pulse_active;
  logic             rise_evt;
  logic             fall_evt;
  logic             int_tick;
  logic             count_tick;
  logic             overflow;
  logic             start_evt;
  logic             stop_evt;
  logic [1:0]       mode;
  logic             run;
  logic             edge_sel;
  logic [2:0]       psc_sel;
  logic             wr_count;
  logic             wr_ctl;

  assign mode     = counter_control[tec_pkg::CTL_MODE_MSB:
                                    tec_pkg::CTL_MODE_LSB];
  assign run      = counter_control[tec_pkg::CTL_RUN];
  assign edge_sel = counter_control[tec_pkg::CTL_EDGE];
  assign psc_sel  = counter_control[tec_pkg::CTL_PSC_MSB:tec_pkg::CTL_PSC_LSB];
  assign wr_count = wr_i && (addr_i == tec_pkg::ADDR_COUNT_VALUE);
  assign wr_ctl   = wr_i && (addr_i == tec_pkg::ADDR_COUNTER_CTRL);

  // pin passes three flops; a change counts once stages 2 and 3 agree
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], count_pin_i};
    end
  end

  // filtered level, only moves when the last two stages agree
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_level <= 1'b0;
    end else if (pin_sync[2] == pin_sync[1]) begin
      pin_level <= pin_sync[2];
    end
  end

  assign rise_evt = (pin_sync[2] == pin_sync[1]) && pin_sync[2] && !pin_level;
  assign fall_evt = (pin_sync[2] == pin_sync[1]) && !pin_sync[2] && pin_level;

  // free running prescaler; a tick when the low field bits roll over
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      psc_cnt <= '0;
    end else begin
      psc_cnt <= psc_cnt + 1'b1;
    end
  end

  // tick only when every selected low stage is at one
  always_comb begin
    int_tick = 1'b1;
    for (int i = 0; i < PSC_W; i++) begin
      if (i < int'(psc_sel) && !psc_cnt[i]) begin
        int_tick = 1'b0;
      end
    end
  end

  // pulse edges: start on the selected edge, stop on the opposite one
  assign start_evt = edge_sel ? rise_evt : fall_evt;
  assign stop_evt  = edge_sel ? fall_evt : rise_evt;

  // counting source per mode; the unused mode never counts
  always_comb begin
    case (mode)
      tec_pkg::MODE_EVENT: count_tick = edge_sel ? fall_evt : rise_evt;
      tec_pkg::MODE_TIMER: count_tick = int_tick;
      tec_pkg::MODE_PULSE: count_tick = int_tick && pulse_active;
      default:             count_tick = 1'b0;
    endcase
  end

  // a read freezes the count for that cycle so the returned byte is whole
  assign overflow = run && count_tick && !rd_i
                    && (count_value == tec_pkg::COUNT_MAX);

  // pulse window tracking; edges ignored once run is cleared
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_active <= 1'b0;
    end else if (mode != tec_pkg::MODE_PULSE || !run) begin
      pulse_active <= 1'b0;
    end else if (!pulse_active && start_evt) begin
      pulse_active <= 1'b1;
    end else if (pulse_active && stop_evt) begin
      pulse_active <= 1'b0;
    end
  end

  // preload keeps the last write to the count register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      preload <= tec_pkg::COUNT_RESET;
    end else if (wr_count) begin
      preload <= wdata_i;
    end
  end

  // the count itself; reload on overflow in every mode
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_value <= tec_pkg::COUNT_RESET;
    end else if (wr_count && !run) begin
      count_value <= wdata_i;
    end else if (overflow) begin
      count_value <= preload;
    end else if (run && count_tick && !rd_i) begin
      count_value <= count_value + 8'h01;
    end
  end

  // control; hardware clears run only at the end of a pulse measurement
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter_control <= tec_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      counter_control <= wdata_i & ~(8'h01 << tec_pkg::CTL_UNUSED);
    end else if (mode == tec_pkg::MODE_PULSE && pulse_active && stop_evt) begin
      counter_control[tec_pkg::CTL_RUN] <= 1'b0;
    end
  end

  // flag: set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_control <= tec_pkg::IRQ_RESET;
    end else begin
      if (wr_i && addr_i == tec_pkg::ADDR_IRQ_CONTROL) begin
        irq_control <= wdata_i & tec_pkg::IRQ_MASK;
      end
      if (overflow) begin
        irq_control[tec_pkg::IRQ_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_a_latch <= tec_pkg::LATCH_RESET;
    end else if (wr_i && addr_i == tec_pkg::ADDR_PORT_A_LATCH) begin
      port_a_latch <= wdata_i;
    end
  end

  // divide-by-two of the overflow rate
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_toggle <= 1'b0;
    end else if (overflow) begin
      div_toggle <= !div_toggle;
    end
  end

  // outputs, each from a flop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      freq_divider_out_o <= 1'b0;
      irq_o              <= 1'b0;
      wake_o             <= 1'b0;
    end else begin
      freq_divider_out_o <= freq_div_option_i
                            && port_a_latch[tec_pkg::LATCH_DIV_BIT]
                            && div_toggle;
      irq_o  <= irq_control[tec_pkg::IRQ_FLAG_BIT]
                && irq_control[tec_pkg::IRQ_ENABLE_BIT];
      wake_o <= overflow;
    end
  end

  // read port; unmapped addresses answer zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= tec_pkg::ZERO8;
    end else if (rd_i) begin
      case (addr_i)
        tec_pkg::ADDR_COUNT_VALUE:  rdata_o <= count_value;
        tec_pkg::ADDR_COUNTER_CTRL: rdata_o <= counter_control;
        tec_pkg::ADDR_IRQ_CONTROL:  rdata_o <= irq_control;
        tec_pkg::ADDR_PORT_A_LATCH: rdata_o <= port_a_latch;
        tec_pkg::ADDR_STATUS: begin
          rdata_o <= tec_pkg::ZERO8;
          rdata_o[tec_pkg::ST_OVF_BIT] <= irq_control[tec_pkg::IRQ_FLAG_BIT];
          rdata_o[tec_pkg::ST_DIV_BIT] <= div_toggle;
        end
        default: rdata_o <= tec_pkg::ZERO8;
      endcase
    end else begin
      rdata_o <= tec_pkg::ZERO8;
    end
  end

  // checks
  property p_reload;
    @(posedge sys_clk_i) disable iff (rst_i)
      overflow && !(wr_count && !run) |=> count_value == $past(preload);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_flag;
    @(posedge sys_clk_i) disable iff (rst_i)
      overflow |=> irq_control[tec_pkg::IRQ_FLAG_BIT];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");

  property p_hold_read;
    @(posedge sys_clk_i) disable iff (rst_i)
      rd_i && !wr_count |=> $stable(count_value);
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("read moved");

  property p_stopped;
    @(posedge sys_clk_i) disable iff (rst_i)
      !run && !wr_count |=> $stable(count_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counted stopped");

  property p_run_kept;
    @(posedge sys_clk_i) disable iff (rst_i)
      run && mode != tec_pkg::MODE_PULSE && !wr_ctl |=> run;
  endproperty
  a_run_kept: assert property (p_run_kept) else $error("run cleared");

  property p_wake;
    @(posedge sys_clk_i) disable iff (rst_i) overflow |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_irq_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
      !irq_control[tec_pkg::IRQ_ENABLE_BIT] |=> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");

  property p_bit5;
    @(posedge sys_clk_i) disable iff (rst_i)
      !counter_control[tec_pkg::CTL_UNUSED];
  endproperty
  a_bit5: assert property (p_bit5) else $error("bit 5 set");

  property p_toggle;
    @(posedge sys_clk_i) disable iff (rst_i)
      overflow |=> div_toggle != $past(div_toggle);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_pulse_end;
    @(posedge sys_clk_i) disable iff (rst_i)
      mode == tec_pkg::MODE_PULSE && pulse_active && stop_evt && !wr_ctl
      |=> !run;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("run kept");

  // a count read returns the value that stood at the strobe
  property p_read_count;
    @(posedge sys_clk_i) disable iff (rst_i)
      rd_i && addr_i == tec_pkg::ADDR_COUNT_VALUE
      |=> rdata_o == $past(count_value);
  endproperty
  a_read_count: assert property (p_read_count) else $error("bad read");

  // a plain tick adds exactly one
  property p_step;
    @(posedge sys_clk_i) disable iff (rst_i)
      run && count_tick && !rd_i && !overflow && !wr_count
      |=> count_value == $past(count_value) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("bad step");

  // stopped write lands in the counter at once
  property p_load_stopped;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_count && !run |=> count_value == $past(wdata_i);
  endproperty
  a_load_stopped: assert property (p_load_stopped) else $error("no load");

  // every count write reaches the preload
  property p_preload;
    @(posedge sys_clk_i) disable iff (rst_i)
      wr_count |=> preload == $past(wdata_i);
  endproperty
  a_preload: assert property (p_preload) else $error("no preload");

  // no window opens outside an armed pulse measurement
  property p_pulse_idle;
    @(posedge sys_clk_i) disable iff (rst_i)
      mode != tec_pkg::MODE_PULSE || !run |=> !pulse_active;
  endproperty
  a_pulse_idle: assert property (p_pulse_idle) else $error("armed");

  // undivided timer ticks every cycle
  property p_timer_tick;
    @(posedge sys_clk_i) disable iff (rst_i)
      mode == tec_pkg::MODE_TIMER && psc_sel == 3'h0 |-> count_tick;
  endproperty
  a_timer_tick: assert property (p_timer_tick) else $error("no tick");

  // the unused mode must never count
  property p_mode_idle;
    @(posedge sys_clk_i) disable iff (rst_i)
      mode == tec_pkg::MODE_UNUSED |-> !count_tick;
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("idle counts");

  // divider pin stays low unless option and latch bit allow it
  property p_div_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
      !(freq_div_option_i && port_a_latch[tec_pkg::LATCH_DIV_BIT])
      |=> !freq_divider_out_o;
  endproperty
  a_div_gate: assert property (p_div_gate) else $error("div ungated");

  // wake pulses only after an overflow
  property p_wake_only;
    @(posedge sys_clk_i) disable iff (rst_i) !overflow |=> !wake_o;
  endproperty
  a_wake_only: assert property (p_wake_only) else $error("stray wake");

  c_overflow: cover property (@(posedge sys_clk_i) overflow);
  c_pulse: cover property (@(posedge sys_clk_i)
    pulse_active ##1 !pulse_active);
  c_event: cover property (@(posedge sys_clk_i)
    mode == tec_pkg::MODE_EVENT && count_tick);
  c_read: cover property (@(posedge sys_clk_i) rd_i && run && count_tick);

endmodule : tec_counter
`default_nettype wire

// file: tb/tec_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side source on the event pin; a plain level that moves after an edge
module tec_pin_model (
  input  wire logic sys_clk_i,
  output var  logic count_pin_o
);
  initial count_pin_o = 1'b0;
  // move the pin right after a rising edge, never on the sampling edge
  task automatic set(input logic lvl);
    @(posedge sys_clk_i);
    count_pin_o <= lvl;
  endtask
endmodule // tec_pin_model
`default_nettype wire

// file: tb/timer_event_counter_8bit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer_event_counter_8bit_bench;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [7:0]  addr_i    = 8'h00;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        rd_seen   = 1'b0;
  logic [7:0]  rdata_o;
  logic        count_pin_i;
  logic        freq_divider_out_o;
  logic        irq_o;
  logic        wake_o;
  logic        fq;
  logic        div_opt   = 1'b1;
  logic [7:0]  v;
  logic [7:0]  q[$];
  logic [31:0] s = 32'h1838;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          w, t, p, e;

  // 100 MHz system clock
  always #5 sys_clk_i = ~sys_clk_i;

  tec_counter dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .count_pin_i(count_pin_i), .freq_div_option_i(div_opt),
    .freq_divider_out_o(freq_divider_out_o), .irq_o(irq_o),
    .wake_o(wake_o));

  tec_pin_model pin (.sys_clk_i(sys_clk_i), .count_pin_o(count_pin_i));

  // fixed-seed xorshift so every run sees the same values
  function automatic logic [7:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction

  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [8:0] x, y);
    comparisons++;
    if (y !== x) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, y);
    end
  endtask

  // one bus cycle; a read notes its expected data for the monitor
  task automatic bus(input logic wr, input logic [7:0] a, d);
    @(posedge sys_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= wr;
    rd_i    <= !wr;
    if (!wr) q.push_back(d);
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask

  // count read whose value is judged by range, so no note is queued
  task automatic getc();
    @(posedge sys_clk_i);
    addr_i <= tec_pkg::ADDR_COUNT_VALUE;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    v = rdata_o;
  endtask

  // read data stand only in the cycle after the strobe: look mid-cycle
  always @(posedge sys_clk_i) rd_seen <= rd_i;
  always @(negedge sys_clk_i)
    if (rd_seen && q.size() > 0) check(q.pop_front(), rdata_o);

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // reset values, unused bit and an unmapped address
    bus(0, tec_pkg::ADDR_COUNTER_CTRL, 8'h08);
    bus(0, tec_pkg::ADDR_IRQ_CONTROL, 8'h00);
    bus(0, tec_pkg::ADDR_PORT_A_LATCH, 8'hFF);
    bus(1, 8'h20, xs());
    bus(0, 8'h20, 8'h00);
    bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'h3F);
    bus(0, tec_pkg::ADDR_COUNTER_CTRL, 8'h1F);
    bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'h90);
    bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'h80);
    v = xs();
    bus(1, tec_pkg::ADDR_COUNT_VALUE, v);
    bus(0, tec_pkg::ADDR_COUNT_VALUE, v);
    // timer overflow; the running write reaches the preload only
    bus(1, tec_pkg::ADDR_COUNT_VALUE, 8'hFE);
    bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'h97);
    bus(1, tec_pkg::ADDR_COUNT_VALUE, 8'h40);
    do @(negedge sys_clk_i); while (wake_o !== 1'b1);
    bus(0, tec_pkg::ADDR_COUNTER_CTRL, 8'h97);
    bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'h87);
    bus(0, tec_pkg::ADDR_COUNT_VALUE, 8'h40);
    bus(0, tec_pkg::ADDR_IRQ_CONTROL, 8'h20);
    bus(0, tec_pkg::ADDR_STATUS, 8'h03);
    check(9'h000, {8'h00, irq_o});
    bus(1, tec_pkg::ADDR_IRQ_CONTROL, 8'h24);
    repeat (2) @(negedge sys_clk_i);
    check(9'h001, {8'h00, irq_o});
    bus(1, tec_pkg::ADDR_IRQ_CONTROL, 8'h04);
    repeat (2) @(negedge sys_clk_i);
    check(9'h000, {8'h00, irq_o});
    // preload FF overflows on every tick: rate shows the prescaler
    bus(1, tec_pkg::ADDR_COUNT_VALUE, 8'hFF);
    for (p = 0; p < 10; p++) begin
      if (p == 8) bus(1, tec_pkg::ADDR_PORT_A_LATCH, 8'hF7);
      if (p == 9) bus(1, tec_pkg::ADDR_PORT_A_LATCH, 8'hFF);
      if (p == 9) div_opt <= 1'b0;
      bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'h90 | p[2:0]);
      repeat (260) @(negedge sys_clk_i);
      w = 0;
      t = 0;
      fq = freq_divider_out_o;
      repeat (256) begin
        @(negedge sys_clk_i);
        w += wake_o;
        t += (freq_divider_out_o != fq);
        fq = freq_divider_out_o;
      end
      check(9'(256 >> p[2:0]), 9'(w));
      check(9'(p >= 8 ? 0 : 256 >> p), 9'(t));
    end
    // event mode: a rising pin counts only with edge select 0
    for (e = 0; e < 2; e++) begin
      bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'(8'h40 + 8 * e));
      bus(1, tec_pkg::ADDR_COUNT_VALUE, 8'h00);
      bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'(8'h50 + 8 * e));
      pin.set(1'b1);
      repeat (10) @(negedge sys_clk_i);
      bus(0, tec_pkg::ADDR_COUNT_VALUE, 8'(1 - e));
      pin.set(1'b0);
      repeat (10) @(negedge sys_clk_i);
      bus(0, tec_pkg::ADDR_COUNT_VALUE, 8'h01);
    end
    bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'h40);
    pin.set(1'b1);
    repeat (10) @(negedge sys_clk_i);
    bus(0, tec_pkg::ADDR_COUNT_VALUE, 8'h01);
    // pulse width: one 40-cycle pulse measured, a second one ignored
    for (e = 0; e < 2; e++) begin
      pin.set(!e[0]);
      bus(1, tec_pkg::ADDR_COUNT_VALUE, 8'h00);
      bus(1, tec_pkg::ADDR_COUNTER_CTRL, 8'(8'hD0 + 8 * e));
      repeat (2) begin
        pin.set(e[0]);
        repeat (40) @(negedge sys_clk_i);
        pin.set(!e[0]);
        repeat (10) @(negedge sys_clk_i);
        getc();
        check(9'h001, 9'(v >= 8'd38 && v <= 8'd42));
      end
      bus(0, tec_pkg::ADDR_COUNTER_CTRL, 8'(8'hC0 + 8 * e));
    end
    summarize();
  end
endmodule // timer_event_counter_8bit_bench
`default_nettype wire
